/* core/tdmsp_pkg.sv */
// Purpose: Shared constants and types for the 16-slot serial link framer
// Assumes: Core clock of 25 MHz, link clocks of 6 144 kHz
// Notes:   Slot table packs slot-1 of each phase, phase 0 in the low nibble
package tdmsp_pkg;
  localparam int CORE_KHZ      = 25000;
  localparam int REF_KHZ       = 6144;
  localparam int NCO_BITS      = 16;
  localparam logic [15:0] NCO_STEP =
    16'((2 * REF_KHZ * (1 << NCO_BITS)) / CORE_KHZ);
  localparam int FRAME_PERIODS = 147456;
  localparam int SYNC_PERIODS  = 32;
  localparam int PHASES        = 16;
  localparam int BLOCKS        = 9216;
  localparam int FIFO_DEPTH    = 16;
  localparam logic [63:0] SLOT_MAP = 64'hF7B3D591E6A2C480;
  localparam logic [17:0] CNT_RST  = 18'h23FFF;
  localparam logic [4:0]  SYN_RST  = 5'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;

  typedef enum logic [1:0] {
    DN_OWN,
    DN_PASS,
    DN_INSERT,
    DN_REPLACE
  } tdmsp_dn_mode_t;

  typedef struct packed {
    logic       frame_start;
    logic [3:0] slot;
    logic       data;
  } tdmsp_rx_t;
endpackage

/* core/tdmsp_top.sv */
// Purpose: Framer with a receiving-side and a producing-side serial port
// Assumes: Link clocks far slower than CORE_CLK, sampled through two flops
// Notes:   Summary of operation list below; one FIFO feeds the own data
// Summary of operation
// - Link is five signals: ref clock, ref sync, data clock, data sync, data.
// - Receiving port drives ref clock and sync, accepts data clock, sync, data.
// - Producing port drives data clock, sync, data, accepts ref clock, sync.
// - Receiving port generates the ref clock at 6 144 kHz unless REF_PASS forwards the received one.
// - Ref sync rises once every 147 456 ref clock periods.
// - Ref sync stays high for exactly 32 ref clock periods.
// - Both ref sync edges launched on a falling ref clock edge.
// - Producing port drives the data clock by following the received ref clock.
// - Data sync rises once every 147 456 data clock periods.
// - Data sync stays high for exactly 32 data clock periods.
// - Both data sync edges launched on a falling data clock edge.
// - A frame holds 147 456 one-bit phases within one sync period.
// - Data bit stable at rising data clock; receiver samples there.
// - Frame is 9 216 blocks of sixteen consecutive phases.
// - First phase of first block coincides with data sync rising.
// - Ring node passes received ref signals or replaces them locally.
// - Ring node passes data, inserts own data, or replaces one slot.
// - Producers have both ports; consumers use the receiving port only.
// - Payload is 16 slots, one dedicated phase per block each.
// - Phases 0..15 carry slots 1,9,5,13,3,11,7,15,2,10,6,14,4,12,8,16.
`timescale 1ns/1ns
module tdmsp_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  cnt_r;
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rd_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
      wr_r  <= '0;
      rd_r  <= '0;
    end else begin
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      wr_r  <= push ? wr_r + 1'b1 : wr_r;
      rd_r  <= pop ? rd_r + 1'b1 : rd_r;
    end
  end

  a_fifo_bounds:
  assert property (@(posedge clk) disable iff (rst)
    cnt_r <= (AW+1)'(D))
    else $error("FIFO count beyond depth");
endmodule // tdmsp_fifo

module tdmsp_top #(
  parameter int FRAME_PERIODS = tdmsp_pkg::FRAME_PERIODS
) (
  input  wire logic                      CORE_CLK,
  input  wire logic                      RST,
  input  wire logic                      REF_PASS,
  input  wire tdmsp_pkg::tdmsp_dn_mode_t DN_MODE,
  input  wire logic [15:0]               SLOT_MASK,
  input  wire logic [3:0]                SUB_SLOT,
  input  wire logic                      TX_VALID,
  output logic                           TX_READY,
  input  wire logic [15:0]               TX_WORD,
  output logic                           UP_REF_CLK_O,
  output logic                           UP_REF_SYNC_O,
  input  wire logic                      DN_CLK_I,
  input  wire logic                      DN_SYNC_I,
  input  wire logic                      DN_DATA_I,
  input  wire logic                      UP_REF_CLK_I,
  input  wire logic                      UP_REF_SYNC_I,
  output logic                           DN_CLK_O,
  output logic                           DN_SYNC_O,
  output logic                           DN_DATA_O,
  output logic                           RX_VALID,
  output tdmsp_pkg::tdmsp_rx_t           RX_OUT,
  output logic                           RX_FRAME_ERR
);
  localparam logic [17:0] LAST  = 18'(FRAME_PERIODS - 1);
  localparam logic [17:0] SYNCN = 18'(tdmsp_pkg::SYNC_PERIODS);

  // Pin sampling; index 0..4: dn clk, dn sync, dn data, ref clk, ref sync
  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic [4:0] s3_r;
  // Edge detectors wait until all stages hold pin samples; a pin idling
  // high would otherwise show a false edge right after reset
  logic [2:0] arm_r;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      s1_r  <= tdmsp_pkg::SYN_RST;
      s2_r  <= tdmsp_pkg::SYN_RST;
      s3_r  <= tdmsp_pkg::SYN_RST;
      arm_r <= 3'h0;
    end else begin
      s1_r <= {UP_REF_SYNC_I, UP_REF_CLK_I, DN_DATA_I, DN_SYNC_I, DN_CLK_I};
      s2_r <= s1_r;
      s3_r <= s2_r;
      arm_r <= {arm_r[1:0], 1'b1};
    end
  end

  // Receiving side: local reference generator
  // Fractional divider: 25 MHz cannot divide to 6 144 kHz, so edges jitter
  // by one core cycle while the mean rate is exact within the step rounding.
  logic [15:0] nco_r;
  logic        gclk_r;
  logic        gsync_r;
  logic [17:0] ref_cnt_r;
  wire  [16:0] nco_sum  = {1'b0, nco_r} + {1'b0, tdmsp_pkg::NCO_STEP};
  wire         gclk_nxt = gclk_r ^ nco_sum[16];
  wire         gfall    = gclk_r & ~gclk_nxt;
  wire  [17:0] ref_nxt  = (ref_cnt_r == LAST) ? 18'h00000 : ref_cnt_r + 18'h00001;
  wire         gsync_nxt = gfall ? (ref_nxt < SYNCN) : gsync_r;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      nco_r     <= tdmsp_pkg::WORD_RST;
      gclk_r    <= 1'b0;
      gsync_r   <= 1'b0;
      ref_cnt_r <= LAST;
    end else begin
      nco_r     <= nco_sum[15:0];
      gclk_r    <= gclk_nxt;
      gsync_r   <= gsync_nxt;
      ref_cnt_r <= gfall ? ref_nxt : ref_cnt_r;
    end
  end

  // Ring node may forward the received reference instead
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      UP_REF_CLK_O  <= 1'b0;
      UP_REF_SYNC_O <= 1'b0;
    end else begin
      UP_REF_CLK_O  <= REF_PASS ? s2_r[3] : gclk_nxt;
      UP_REF_SYNC_O <= REF_PASS ? s2_r[4] : gsync_nxt;
    end
  end

  // Receiving side: downstream capture
  logic        rx_sy_prev_r;
  logic [3:0]  rx_ph_r;
  logic [17:0] rx_bits_r;
  logic        rx_lock_r;
  logic [15:0] rx_blk_r;
  logic [15:0] rx_last_r;
  wire         rx_rise  = arm_r[2] & s2_r[0] & ~s3_r[0];
  wire         rx_start = s2_r[1] & ~rx_sy_prev_r;
  wire  [3:0]  rx_ph    = rx_start ? 4'h0 : rx_ph_r + 4'h1;
  wire  [3:0]  rx_slot  = tdmsp_pkg::SLOT_MAP[{rx_ph, 2'b00} +: 4];
  wire  [17:0] rx_bits  = rx_start ? 18'h00000 : rx_bits_r + 18'h00001;
  wire  [15:0] rx_blk_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < tdmsp_pkg::PHASES; gi++) begin : g_rxslot
      assign rx_blk_nxt[gi] = (rx_slot == 4'(gi)) ? s2_r[2] : rx_blk_r[gi];
    end
  endgenerate

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rx_sy_prev_r <= 1'b0;
      rx_ph_r      <= 4'hF;
      rx_bits_r    <= tdmsp_pkg::CNT_RST;
      rx_lock_r    <= 1'b0;
      rx_blk_r     <= tdmsp_pkg::WORD_RST;
      rx_last_r    <= tdmsp_pkg::WORD_RST;
      RX_VALID     <= 1'b0;
      RX_OUT       <= '0;
      RX_FRAME_ERR <= 1'b0;
    end else begin
      RX_VALID     <= rx_rise;
      RX_FRAME_ERR <= rx_rise & rx_start & rx_lock_r & (rx_bits_r != LAST);
      if (rx_rise) begin
        rx_sy_prev_r <= s2_r[1];
        rx_ph_r      <= rx_ph;
        rx_bits_r    <= rx_bits;
        rx_lock_r    <= rx_lock_r | rx_start;
        rx_blk_r     <= rx_blk_nxt;
        rx_last_r    <= (rx_ph == 4'hF) ? rx_blk_nxt : rx_last_r;
        RX_OUT       <= '{frame_start: rx_start, slot: rx_slot, data: s2_r[2]};
      end
    end
  end

  // Producing side: timing taken from the received reference
  logic        tx_align_r;
  logic [17:0] tx_cnt_r;
  logic [15:0] tx_word_r;
  logic        fifo_valid;
  logic [15:0] fifo_data;
  wire         tx_fall  = arm_r[2] & s3_r[3] & ~s2_r[3];
  wire         ref_rise = arm_r[2] & s2_r[4] & ~s3_r[4];
  // A sync rise seen with the clock fall opens period zero on that very fall
  wire  [17:0] tx_nxt   = (ref_rise || tx_align_r || tx_cnt_r == LAST) ? 18'h00000 :
                          tx_cnt_r + 18'h00001;
  wire  [3:0]  tx_ph    = tx_nxt[3:0];
  wire  [3:0]  tx_slot  = tdmsp_pkg::SLOT_MAP[{tx_ph, 2'b00} +: 4];
  wire         tx_pop   = tx_fall & (tx_ph == 4'h0) & fifo_valid;
  wire  [15:0] tx_word  = (tx_ph != 4'h0) ? tx_word_r :
                          (fifo_valid ? fifo_data : tdmsp_pkg::WORD_RST);
  wire         own_sel  = (DN_MODE == tdmsp_pkg::DN_OWN) ||
                          (DN_MODE == tdmsp_pkg::DN_INSERT && SLOT_MASK[tx_slot]) ||
                          (DN_MODE == tdmsp_pkg::DN_REPLACE && SUB_SLOT == tx_slot);
  wire         tx_bit   = own_sel ? tx_word[tx_slot] : rx_last_r[tx_slot];

  tdmsp_fifo #(
    .W (16),
    .D (tdmsp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (CORE_CLK),
    .rst       (RST),
    .in_valid  (TX_VALID),
    .in_ready  (TX_READY),
    .in_data   (TX_WORD),
    .out_valid (fifo_valid),
    .out_ready (tx_pop),
    .out_data  (fifo_data)
  );

  // A sync rise landing between clock falls is held for the next fall
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      tx_align_r <= 1'b0;
      tx_cnt_r   <= LAST;
      tx_word_r  <= tdmsp_pkg::WORD_RST;
      DN_CLK_O   <= 1'b0;
      DN_SYNC_O  <= 1'b0;
      DN_DATA_O  <= 1'b0;
    end else begin
      tx_align_r <= (ref_rise | tx_align_r) & ~tx_fall;
      DN_CLK_O   <= s2_r[3];
      if (tx_fall) begin
        tx_cnt_r  <= tx_nxt;
        tx_word_r <= tx_word;
        DN_SYNC_O <= (tx_nxt < SYNCN);
        DN_DATA_O <= tx_bit;
      end
    end
  end

  // Checking helpers
  logic [5:0]  ref_len_r;
  logic [5:0]  dn_len_r;
  logic [17:0] ref_per_r;
  logic [2:0]  hold_r;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ref_len_r <= 6'h00;
      dn_len_r  <= 6'h00;
      ref_per_r <= LAST;
      hold_r    <= 3'h1;
    end else begin
      ref_len_r <= gfall ? (gsync_r ? ref_len_r + 6'h01 : 6'h00) : ref_len_r;
      dn_len_r  <= tx_fall ? (DN_SYNC_O ? dn_len_r + 6'h01 : 6'h00) : dn_len_r;
      ref_per_r <= !gfall ? ref_per_r :
                   (gsync_nxt & ~gsync_r) ? 18'h00000 : ref_per_r + 18'h00001;
      hold_r    <= (gclk_nxt != gclk_r) ? 3'h1 : hold_r + 3'h1;
    end
  end

  a_ref_sync_width:
  assert property (@(posedge CORE_CLK) disable iff (RST)
    $fell(gsync_r) |-> ref_len_r == 6'd32)
    else $error("Reference sync width is not 32 periods");

  a_ref_sync_edge:
  assert property (@(posedge CORE_CLK) disable iff (RST)
    (gsync_r != $past(gsync_r)) |-> $fell(gclk_r))
    else $error("Reference sync moved off a falling clock edge");

  a_ref_frame_len:
  assert property (@(posedge CORE_CLK) disable iff (RST)
    (gfall && gsync_nxt && !gsync_r) |-> ref_per_r == LAST)
    else $error("Reference frame length wrong");

  a_ref_clk_rate:
  assert property (@(posedge CORE_CLK) disable iff (RST)
    hold_r <= 3'd3)
    else $error("Reference clock half period too long");

  a_dn_sync_width:
  assert property (@(posedge CORE_CLK) disable iff (RST)
    $fell(DN_SYNC_O) |-> dn_len_r == 6'd32)
    else $error("Data sync width is not 32 periods");

  a_dn_sync_edge:
  assert property (@(posedge CORE_CLK) disable iff (RST)
    $changed(DN_SYNC_O) |-> $fell(DN_CLK_O))
    else $error("Data sync moved off a falling clock edge");

  a_dn_first_phase:
  assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(DN_SYNC_O) |-> tx_cnt_r == 18'd0)
    else $error("Frame start not at phase zero");

  a_rx_phase_slot:
  assert property (@(posedge CORE_CLK) disable iff (RST)
    (RX_VALID && RX_OUT.frame_start) |-> RX_OUT.slot == 4'd0 ##0 rx_ph_r == 4'd0)
    else $error("Received frame start not on slot one");

  a_rx_phase_wrap:
  assert property (@(posedge CORE_CLK) disable iff (RST)
    (rx_rise && !rx_start && rx_ph_r == 4'd15) |=> rx_ph_r == 4'd0)
    else $error("Receive phase did not wrap at sixteen");

  a_dn_ref_align:
  assert property (@(posedge CORE_CLK) disable iff (RST)
    (ref_rise && tx_fall) |=> tx_cnt_r == 18'd0)
    else $error("Data frame not aligned to reference sync");

  a_dn_data_hold:
  assert property (@(posedge CORE_CLK) disable iff (RST)
    $changed(DN_DATA_O) |-> $fell(DN_CLK_O))
    else $error("Data changed away from a falling clock edge");

  a_dn_pop_block:
  assert property (@(posedge CORE_CLK) disable iff (RST)
    tx_pop |-> tx_nxt[3:0] == 4'h0)
    else $error("Own word taken away from a block start");
endmodule // tdmsp_top

/* tb/tdmsp_far_model.sv */
// Purpose: Far-side model, reference source and data producer
// Assumes: One link clock serves both groups; lines change on its fall
// Notes:   Clock idles high before go; short_frm gives one 128-period frame
`timescale 1ns/1ns
module tdmsp_far_model #(
  parameter int FRAME = 256
) (
  input  wire logic go,
  input  wire logic short_frm,
  output logic      lclk,
  output logic      lsync,
  output logic      ldata
);
  int   cnt = 0;
  int   flen = FRAME;
  int   k = 0;
  int   seed = 37;
  logic sent [0:4095];
  int   phq [$];
  logic dq [$];
  initial begin
    lclk = 1'b1;
    lsync = 1'b0;
    ldata = 1'b0;
    wait (go === 1'b1);
    #13;
    forever begin
      lclk = 1'b0;
      lsync = cnt < 32;
      ldata = 1'($random(seed));
      sent[k % 4096] = ldata;
      #160;
      lclk = 1'b1;
      phq.push_back(cnt);
      dq.push_back(ldata);
      #160;
      k = k + 1;
      if (cnt == flen - 1) begin
        cnt = 0;
        flen = short_frm ? 128 : FRAME;
      end else begin
        cnt = cnt + 1;
      end
    end
  end
endmodule // tdmsp_far_model

/* tb/tdmsp_top_tb_top.sv */
// Purpose: Self-checking bench for the serial link framer
// Assumes: Far model loops the link; frames shortened to 256 periods
// Notes:   Own-data model pops one word per block; pass mode runs last
`timescale 1ns/1ns
module tdmsp_top_tb_top;
  localparam int FR = 256;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ref_pass = 1'b0;
  logic tx_valid = 1'b0;
  logic go = 1'b0;
  logic short_frm = 1'b0;
  logic [15:0] slot_mask = 16'h0000;
  logic [15:0] tx_word = 16'h0000;
  logic [3:0] sub_slot = 4'h0;
  tdmsp_pkg::tdmsp_dn_mode_t dn_mode = tdmsp_pkg::DN_OWN;
  logic tx_ready, urc_o, urs_o, dclk_o, dsync_o, ddata_o, rx_valid, rx_err;
  logic lclk, lsync, ldata, dprev, rp_c, rp_s;
  tdmsp_pkg::tdmsp_rx_t rx_out;
  logic [2:0] shc = 3'h0;
  logic [2:0] shs = 3'h0;
  logic [15:0] wq [$];
  logic [15:0] cur;
  int mismatches, cmp_count, k, errs, rp, per, fcyc;
  int seed = 37;
  bit skip, pass_chk, seen_rise;
  int tbl [16] = '{0, 8, 4, 12, 2, 10, 6, 14, 1, 9, 5, 13, 3, 11, 7, 15};
  int inv [16];
  always #20 clk = ~clk;
  tdmsp_top #(.FRAME_PERIODS(FR)) dut_u (.CORE_CLK(clk), .RST(rst), .REF_PASS(ref_pass),
    .DN_MODE(dn_mode), .SLOT_MASK(slot_mask), .SUB_SLOT(sub_slot), .TX_VALID(tx_valid),
    .TX_READY(tx_ready), .TX_WORD(tx_word), .UP_REF_CLK_O(urc_o), .UP_REF_SYNC_O(urs_o),
    .DN_CLK_I(lclk), .DN_SYNC_I(lsync), .DN_DATA_I(ldata), .UP_REF_CLK_I(lclk),
    .UP_REF_SYNC_I(lsync), .DN_CLK_O(dclk_o), .DN_SYNC_O(dsync_o), .DN_DATA_O(ddata_o),
    .RX_VALID(rx_valid), .RX_OUT(rx_out), .RX_FRAME_ERR(rx_err));
  tdmsp_far_model #(.FRAME(FR)) far_u (.go(go), .short_frm(short_frm), .lclk(lclk),
    .lsync(lsync), .ldata(ldata));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic exp_bit(input int kk);
    int s;
    logic rb;
    s = tbl[kk % 16];
    rb = far_u.sent[((kk / 16 - 1) * 16 + inv[s]) % 4096];
    case (dn_mode)
      tdmsp_pkg::DN_OWN:    return cur[s];
      tdmsp_pkg::DN_PASS:   return rb;
      tdmsp_pkg::DN_INSERT: return slot_mask[s] ? cur[s] : rb;
      default:              return (s == int'(sub_slot)) ? cur[s] : rb;
    endcase
  endfunction
  // Word accepted only when both sides agree at the edge
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      wq.push_back(tx_word);
      tx_word <= 16'($random(seed));
    end
  end
  always @(posedge clk) begin
    if (rx_valid === 1'b1 && far_u.phq.size() > 0) begin
      rp = far_u.phq.pop_front();
      chk(rx_out.data, far_u.dq.pop_front());
      chk(rx_out.slot, tbl[rp % 16]);
      chk(rx_out.frame_start, rp == 0);
    end
    if (rx_err === 1'b1) errs++;
  end
  always @(posedge clk) begin
    dprev <= dclk_o;
    if (go === 1'b1 && dprev === 1'b0 && dclk_o === 1'b1) begin
      if (k % 16 == 0) begin
        cur = (wq.size() > 0) ? wq.pop_front() : 16'h0000;
        skip = 0;
      end
      chk(dsync_o, far_u.cnt < 32);
      if (!skip && far_u.flen == FR) chk(ddata_o, exp_bit(k));
      k++;
    end
  end
  always @(posedge clk) begin
    rp_c <= urc_o;
    rp_s <= urs_o;
    shc <= {shc[1:0], lclk};
    shs <= {shs[1:0], lsync};
    if (go === 1'b1) chk(dclk_o, shc[2]);
    if (pass_chk) chk({urc_o, urs_o}, {shc[2], shs[2]});
    if (rst === 1'b0 && ref_pass === 1'b0) begin
      fcyc++;
      if (urs_o !== rp_s) chk(rp_c & ~urc_o, 1'b1);
      if (rp_c === 1'b1 && urc_o === 1'b0) per++;
      if (rp_s === 1'b0 && urs_o === 1'b1) begin
        if (seen_rise) chk(per, FR);
        if (seen_rise) chk(fcyc inside {[1039:1044]}, 1'b1);
        per = 0;
        fcyc = 0;
        seen_rise = 1;
      end
      if (rp_s === 1'b1 && urs_o === 1'b0) chk(per, 32);
    end
  end
  task blocks(input int n);
    repeat (n * 128) @(posedge clk);
  endtask
  // Changes land mid-block, away from the pop at phase 0
  task mid_block(input tdmsp_pkg::tdmsp_dn_mode_t m);
    do @(negedge clk); while (k % 16 != 8);
    @(posedge clk);
    dn_mode <= m;
    slot_mask <= 16'($random(seed));
    sub_slot <= 4'($random(seed));
    skip = 1;
  endtask
  initial begin
    #2000000;
    mismatches++;
    conclude();
  end
  initial begin
    for (int i = 0; i < 16; i++) inv[tbl[i]] = i;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({tx_ready, rx_valid, dsync_o, urs_o}, 4'h8);
    @(posedge clk);
    tx_valid <= 1'b1;
    repeat (24) @(posedge clk);
    @(negedge clk);
    chk(tx_ready, 1'b0);
    chk(wq.size(), 16);
    @(posedge clk);
    go <= 1'b1;
    blocks(40);
    mid_block(tdmsp_pkg::DN_OWN);
    tx_valid <= 1'b0;
    blocks(20);
    mid_block(tdmsp_pkg::DN_OWN);
    tx_valid <= 1'b1;
    blocks(4);
    mid_block(tdmsp_pkg::DN_INSERT);
    blocks(12);
    mid_block(tdmsp_pkg::DN_REPLACE);
    blocks(12);
    mid_block(tdmsp_pkg::DN_PASS);
    blocks(12);
    @(posedge clk);
    ref_pass <= 1'b1;
    repeat (8) @(posedge clk);
    pass_chk = 1;
    blocks(2);
    chk(errs, 0);
    short_frm <= 1'b1;
    wait (far_u.flen == 128);
    @(posedge clk);
    short_frm <= 1'b0;
    repeat (3200) @(posedge clk);
    chk(errs, 1);
    conclude();
  end
endmodule // tdmsp_top_tb_top
